// file: rre_map.vh
// Opcode fields and timing constants for the return and rotate executor.
// Assumes 14-bit instruction words and an 8-bit datapath.
`ifndef RRE_MAP_VH
`define RRE_MAP_VH
// ************************************************************
// Opcode fields
// ************************************************************
`define RRE_OP_MSB 13
`define RRE_DEST_BIT 7
`define RRE_FADDR_MSB 6
`define RRE_ROT_OP_LSB 8
`define RRE_ROT_LEFT_OP 6'h0d
`define RRE_ROT_RIGHT_OP 6'h0c
`define RRE_RETLIT_OP_LSB 10
`define RRE_RETLIT_OP 4'hd
`define RRE_RETURN_WORD 14'h0008
// ************************************************************
// Timing
// ************************************************************
`define RRE_RET_CYCLES 2'h2
`define RRE_FLUSH_CYCLES 2'h1
`endif

// file: rre_rotate.v
// Rotate-through-carry unit for one byte.
// Assumes carry and data come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module rre_rotate #(
   parameter WIDTH = 8
) (
   input wire left,
   input wire [WIDTH-1:0] din,
   input wire cin,
   output wire [WIDTH-1:0] dout,
   output wire cout
);
   // Old carry enters the vacated end; the bit pushed out becomes carry
   assign dout = left ? {din[WIDTH-2:0], cin} : {cin, din[WIDTH-1:1]};
   assign cout = left ? din[WIDTH-1] : din[0];
endmodule // rre_rotate
`default_nettype wire

// file: rre_exec.v
// Decode and execute of literal return, subroutine return and rotates.
// Assumes the file register read data is valid in the decode cycle.
`timescale 1ns/1ns
`default_nettype none
`include "rre_map.vh"
module rre_exec #(
   parameter DATA_W = 8,
   parameter PC_W = 13,
   parameter FA_W = 7
) (
   // Clock and reset
   input wire CLK_SYS,
   input wire RST,
   // Instruction from fetch
   input wire INSTR_VALID,
   input wire [13:0] INSTR,
   // Datapath state
   input wire [DATA_W-1:0] FILE_RDATA,
   input wire CARRY_IN,
   input wire [PC_W-1:0] STACK_TOP_ENTRY,
   // Results
   output reg ACC_WE,
   output reg [DATA_W-1:0] ACC_WDATA,
   output reg FILE_WE,
   output reg [FA_W-1:0] FILE_ADDR,
   output reg [DATA_W-1:0] FILE_WDATA,
   output reg CARRY_WE,
   output reg CARRY_OUT,
   output reg PC_LOAD,
   output reg [PC_W-1:0] PC_WDATA,
   output reg STACK_POP,
   output reg FETCH_FLUSH,
   output reg BUSY
);
   // ************************************************************
   // Decode
   // ************************************************************
   wire is_retlit;
   wire is_return;
   wire is_rol;
   wire is_ror;
   wire is_rot;
   wire dest_file;
   wire [DATA_W-1:0] rot_data;
   wire rot_carry;
   assign is_retlit = INSTR_VALID &
      (INSTR[`RRE_OP_MSB:`RRE_RETLIT_OP_LSB] == `RRE_RETLIT_OP);
   assign is_return = INSTR_VALID & (INSTR == `RRE_RETURN_WORD);
   assign is_rol = INSTR_VALID &
      (INSTR[`RRE_OP_MSB:`RRE_ROT_OP_LSB] == `RRE_ROT_LEFT_OP);
   assign is_ror = INSTR_VALID &
      (INSTR[`RRE_OP_MSB:`RRE_ROT_OP_LSB] == `RRE_ROT_RIGHT_OP);
   assign is_rot = is_rol | is_ror;
   assign dest_file = INSTR[`RRE_DEST_BIT];

   rre_rotate #(
      .WIDTH(DATA_W)
   ) u_rot (
      .left(is_rol),
      .din(FILE_RDATA),
      .cin(CARRY_IN),
      .dout(rot_data),
      .cout(rot_carry)
   );

   // ************************************************************
   // Return sequencing
   // ************************************************************
   // Second cycle of a return only flushes the fetched word; decode
   // needs ret_cnt_r at zero, so a word offered meanwhile is ignored.
   reg [1:0] ret_cnt_r;
   reg [1:0] ret_cnt_nxt;
   wire start;
   assign start = (ret_cnt_r == 2'h0);
   always @* begin
      ret_cnt_nxt = ret_cnt_r;
      if (start && (is_retlit || is_return)) begin
         ret_cnt_nxt = `RRE_RET_CYCLES - `RRE_FLUSH_CYCLES;
      end else if (ret_cnt_r != 2'h0) begin
         ret_cnt_nxt = ret_cnt_r - 2'h1;
      end
   end

   // ************************************************************
   // Instruction class
   // ************************************************************
   // Opcode groups are disjoint, so the priority order below only
   // decides for words that no legal program contains.
   localparam CLS_NONE = 2'b00;
   localparam CLS_RETLIT = 2'b01;
   localparam CLS_RETURN = 2'b10;
   localparam CLS_ROT = 2'b11;

   reg [1:0] op_class;
   always @* begin
      op_class = CLS_NONE;
      if (start && is_retlit) begin
         op_class = CLS_RETLIT;
      end else if (start && is_return) begin
         op_class = CLS_RETURN;
      end else if (start && is_rot) begin
         op_class = CLS_ROT;
      end
   end

   // ************************************************************
   // Next values
   // ************************************************************
   // Strobes default to idle and data to its held value; only the
   // winning class overrides them.
   reg acc_we_nxt;
   reg [DATA_W-1:0] acc_wdata_nxt;
   reg file_we_nxt;
   reg [DATA_W-1:0] file_wdata_nxt;
   reg carry_we_nxt;
   reg carry_out_nxt;
   reg pc_load_nxt;
   reg [PC_W-1:0] pc_wdata_nxt;
   reg stack_pop_nxt;
   reg fetch_flush_nxt;

   always @* begin
      acc_we_nxt = 1'b0;
      acc_wdata_nxt = ACC_WDATA;
      file_we_nxt = 1'b0;
      file_wdata_nxt = FILE_WDATA;
      carry_we_nxt = 1'b0;
      carry_out_nxt = CARRY_OUT;
      pc_load_nxt = 1'b0;
      pc_wdata_nxt = PC_WDATA;
      stack_pop_nxt = 1'b0;
      fetch_flush_nxt = 1'b0;
      case (op_class)
         CLS_RETLIT: begin
            acc_we_nxt = 1'b1;
            acc_wdata_nxt = INSTR[DATA_W-1:0];
            pc_load_nxt = 1'b1;
            pc_wdata_nxt = STACK_TOP_ENTRY;
            stack_pop_nxt = 1'b1;
            fetch_flush_nxt = 1'b1;
         end
         CLS_RETURN: begin
            pc_load_nxt = 1'b1;
            pc_wdata_nxt = STACK_TOP_ENTRY;
            stack_pop_nxt = 1'b1;
            fetch_flush_nxt = 1'b1;
         end
         CLS_ROT: begin
            // Single cycle; only carry among the flags is written
            carry_we_nxt = 1'b1;
            carry_out_nxt = rot_carry;
            if (dest_file) begin
               file_we_nxt = 1'b1;
               file_wdata_nxt = rot_data;
            end else begin
               acc_we_nxt = 1'b1;
               acc_wdata_nxt = rot_data;
            end
         end
         default: begin
            // Nothing taken: every strobe stays low
            acc_we_nxt = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // Strobes
   // ************************************************************
   // Counter and BUSY share one next value, so they never disagree.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         ret_cnt_r <= 2'h0;
         ACC_WE <= 1'b0;
         FILE_WE <= 1'b0;
         CARRY_WE <= 1'b0;
         PC_LOAD <= 1'b0;
         STACK_POP <= 1'b0;
         FETCH_FLUSH <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         ret_cnt_r <= ret_cnt_nxt;
         ACC_WE <= acc_we_nxt;
         FILE_WE <= file_we_nxt;
         CARRY_WE <= carry_we_nxt;
         PC_LOAD <= pc_load_nxt;
         STACK_POP <= stack_pop_nxt;
         FETCH_FLUSH <= fetch_flush_nxt;
         BUSY <= (ret_cnt_nxt != 2'h0);
      end
   end

   // ************************************************************
   // Data holds
   // ************************************************************
   // Data outputs keep their last write so the datapath may sample late;
   // FILE_ADDR follows the word every cycle to address the FILE_WE write.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         ACC_WDATA <= {DATA_W{1'b0}};
         FILE_ADDR <= {FA_W{1'b0}};
         FILE_WDATA <= {DATA_W{1'b0}};
         CARRY_OUT <= 1'b0;
         PC_WDATA <= {PC_W{1'b0}};
      end else begin
         ACC_WDATA <= acc_wdata_nxt;
         FILE_ADDR <= INSTR[`RRE_FADDR_MSB:0];
         FILE_WDATA <= file_wdata_nxt;
         CARRY_OUT <= carry_out_nxt;
         PC_WDATA <= pc_wdata_nxt;
      end
   end
endmodule // rre_exec
`default_nettype wire

// file: rre_exec_monitor.sv
// Checker for the return and rotate executor.
// Assumes it is bound to rre_exec with 8-bit data.
`timescale 1ns/1ns
`default_nettype none
module rre_exec_monitor (
   input wire CLK_SYS, RST, INSTR_VALID, CARRY_IN, BUSY, ACC_WE, FILE_WE,
   input wire CARRY_WE, CARRY_OUT, PC_LOAD, STACK_POP, FETCH_FLUSH,
   input wire [13:0] INSTR,
   input wire [7:0] FILE_RDATA, ACC_WDATA, FILE_WDATA,
   input wire [12:0] STACK_TOP_ENTRY, PC_WDATA,
   input wire [6:0] FILE_ADDR
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Taken only when idle; the busy cycle swallows the fetched word
   wire t = INSTR_VALID & ~BUSY;
   wire [7:0] res = ACC_WE ? ACC_WDATA : FILE_WDATA;
   a_retlit_acc: assert property (t && INSTR[13:10] == 4'hd |=> ACC_WE &&
      ACC_WDATA == $past(INSTR[7:0]) && PC_WDATA == $past(STACK_TOP_ENTRY))
      else $error("literal return data wrong");
   a_return_pop: assert property (t && INSTR == 14'h0008 |=> STACK_POP &&
      PC_LOAD && PC_WDATA == $past(STACK_TOP_ENTRY)) else $error("pop wrong");
   a_return_two: assert property (t && INSTR == 14'h0008 |=>
      BUSY && !CARRY_WE ##1 !BUSY && !PC_LOAD) else $error("return timing");
   a_rotl_value: assert property (t && INSTR[13:8] == 6'h0d |=> CARRY_WE &&
      CARRY_OUT == $past(FILE_RDATA[7]) &&
      res == {$past(FILE_RDATA[6:0]), $past(CARRY_IN)}) else $error("rotl");
   a_rot_dest: assert property (t && INSTR[13:9] == 5'h06 |=>
      FILE_WE == $past(INSTR[7]) && ACC_WE != $past(INSTR[7]))
      else $error("rotate destination wrong");
   a_rotl_addr: assert property (t && INSTR[13:8] == 6'h0d |=>
      FILE_ADDR == $past(INSTR[6:0])) else $error("file address wrong");
   a_rotr_value: assert property (t && INSTR[13:8] == 6'h0c |=> !PC_LOAD &&
      CARRY_OUT == $past(FILE_RDATA[0]) &&
      res == {$past(CARRY_IN), $past(FILE_RDATA[7:1])}) else $error("rotr");
   a_retlit_flush: assert property (t && INSTR[13:10] == 4'hd |=>
      FETCH_FLUSH && BUSY && !CARRY_WE ##1 !BUSY && !ACC_WE)
      else $error("literal return timing");
endmodule // rre_exec_monitor
bind rre_exec rre_exec_monitor i_mon (.*);
`default_nettype wire

// file: tb_rre_exec.sv
// Testbench for the return and rotate executor.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin failures++; \
 $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_rre_exec;
   logic CLK_SYS = 0, RST = 1, INSTR_VALID = 0, CARRY_IN = 0, ACC_WE;
   logic FILE_WE, CARRY_WE, CARRY_OUT, PC_LOAD, STACK_POP, FETCH_FLUSH, BUSY;
   logic [13:0] INSTR = 0;
   logic [7:0] FILE_RDATA = 0, ACC_WDATA, FILE_WDATA, r;
   logic [12:0] STACK_TOP_ENTRY = 0, PC_WDATA;
   logic [6:0] FILE_ADDR;
   integer failures = 0, checked = 0, seed = 4, cyc = 0, n, k, w;
   rre_exec i_dut (.*);
   initial forever #5 CLK_SYS = ~CLK_SYS;
   task end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // About 475 cycles are needed (575 at most); anything far beyond is a hang
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         end_sim;
      end
   end
   // Reference model: predicts every output cycle from the rules alone
   integer m_busy = 0, m_acc = 0, m_fil = 0, m_cy = 0, m_pc = 0, m_fa = 0;
   integer s_acc, s_fil, s_cy, s_pc;
   logic [7:0] m_res;
   logic [43:0] exp_q[$];
   logic [43:0] e;
   logic [43:0] d;
   always @(posedge CLK_SYS) begin
      s_acc = 0;
      s_fil = 0;
      s_cy = 0;
      s_pc = 0;
      m_fa = INSTR[6:0];
      if (RST) begin
         m_busy = 0;
         m_acc = 0;
         m_fil = 0;
         m_cy = 0;
         m_pc = 0;
         m_fa = 0;
      end else if (m_busy != 0) begin
         m_busy = 0;
      end else if (INSTR_VALID && (INSTR == 14'h0008 ||
            INSTR[13:10] == 4'hd)) begin
         m_busy = 1;
         s_pc = 1;
         m_pc = STACK_TOP_ENTRY;
         if (INSTR[13]) begin
            s_acc = 1;
            m_acc = INSTR[7:0];
         end
      end else if (INSTR_VALID && INSTR[13:9] == 5'h06) begin
         s_cy = 1;
         m_cy = INSTR[8] ? FILE_RDATA[7] : FILE_RDATA[0];
         m_res = INSTR[8] ? {FILE_RDATA[6:0], CARRY_IN} :
            {CARRY_IN, FILE_RDATA[7:1]};
         if (INSTR[7]) begin
            s_fil = 1;
            m_fil = m_res;
         end else begin
            s_acc = 1;
            m_acc = m_res;
         end
      end
      exp_q.push_back({s_acc[0], s_fil[0], s_cy[0], m_cy[0], s_pc[0],
         s_pc[0], s_pc[0], m_busy[0], m_acc[7:0], m_fil[7:0], m_fa[6:0],
         m_pc[12:0]});
   end
   always @(negedge CLK_SYS) begin
      if (exp_q.size() != 0) begin
         e = exp_q.pop_front();
         d = {ACC_WE, FILE_WE, CARRY_WE, CARRY_OUT, PC_LOAD, STACK_POP,
            FETCH_FLUSH, BUSY, ACC_WDATA, FILE_WDATA, FILE_ADDR, PC_WDATA};
         `CHK(d, e)
      end
   end
   initial begin
      repeat (20) @(negedge CLK_SYS);
      RST = 0;
      @(negedge CLK_SYS);
      `CHK({ACC_WE, FILE_WE, PC_LOAD, BUSY}, 4'h0)
      for (n = 0; n < 200; n++) begin
         k = {$random(seed)} % 4;
         w = $random(seed);
         INSTR = k == 0 ? 14'h0008 : k == 1 ? {4'hd, w[9:0]} :
            {5'h06, k == 2, w[7:0]};
         FILE_RDATA = w[15:8];
         CARRY_IN = w[16];
         STACK_TOP_ENTRY = w[29:17];
         INSTR_VALID = 1;
         @(negedge CLK_SYS);
         if (k < 2) begin
            `CHK({PC_LOAD, STACK_POP, FETCH_FLUSH, BUSY, PC_WDATA}, {4'hf, w[29:17]})
            `CHK({CARRY_WE, ACC_WE, k == 1 ? ACC_WDATA : w[7:0]}, {1'b0, k == 1, w[7:0]})
            // A rotate offered in the busy cycle must be dropped
            INSTR = {7'h1b, w[6:0]};
            @(negedge CLK_SYS);
            `CHK({BUSY, PC_LOAD, FILE_WE, ACC_WE, CARRY_WE}, 5'h0)
         end else begin
            r = k == 2 ? {w[14:8], w[16]} : {w[16], w[15:9]};
            `CHK({CARRY_WE, CARRY_OUT, BUSY, PC_LOAD}, {1'b1, k == 2 ? w[15] : w[8], 2'b0})
            `CHK(w[7] ? {FILE_WE, ACC_WE, FILE_WDATA} : {ACC_WE, FILE_WE, ACC_WDATA}, {2'b10, r})
            `CHK(FILE_ADDR, w[6:0])
         end
      end
      $display("random mix test done");
      // Free words: random words, valid or not, checked against the reference model
      for (n = 0; n < 150; n++) begin
         w = $random(seed);
         INSTR = w[13:0];
         INSTR_VALID = w[14];
         FILE_RDATA = w[22:15];
         CARRY_IN = w[23];
         STACK_TOP_ENTRY = w[31:19];
         @(negedge CLK_SYS);
      end
      $display("free word test done");
      // Reset in the flush cycle of a return must end it at once
      INSTR = 14'h0008;
      INSTR_VALID = 1;
      @(negedge CLK_SYS);
      RST = 1;
      @(negedge CLK_SYS);
      `CHK({BUSY, PC_LOAD, STACK_POP}, 3'h0)
      RST = 0;
      INSTR_VALID = 0;
      @(negedge CLK_SYS);
      @(negedge CLK_SYS);
      $display("mid-run reset test done");
      end_sim;
   end
endmodule // tb_rre_exec
`default_nettype wire
